// ==== pkg/sjng_pkg.sv ====
// Purpose: Constants and types of the judgment and noise guard block
// Assumes: 16-bit register port, 6-bit word addresses, 20 MHz system clock
// Notes: Settings reset to their shipping defaults
package sjng_pkg;
  // ****
  // Timing
  // ****
  localparam int CLK_HZ = 20_000_000;
  localparam int SEC_TIME_S = 1;
  localparam int SEC_CYCLES_DEF = CLK_HZ * SEC_TIME_S;
  localparam logic [15:0] LINGER_TIME_S = 16'h003C;
  localparam logic [15:0] HOLD_MIN_S = 16'h0014;
  // ****
  // Register addresses
  // ****
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_SINGLE = 6'h01;
  localparam logic [5:0] ADDR_CROSS_X = 6'h02;
  localparam logic [5:0] ADDR_CROSS_Z = 6'h04;
  localparam logic [5:0] ADDR_ZCN_TIME = 6'h05;
  localparam logic [5:0] ADDR_CONT_FAIL = 6'h06;
  localparam logic [5:0] ADDR_HOLD = 6'h07;
  localparam logic [5:0] ADDR_LPF = 6'h08;
  localparam logic [5:0] ADDR_LIQ_SI = 6'h09;
  localparam logic [5:0] ADDR_LIQ_ZC = 6'h0C;
  localparam logic [5:0] ADDR_JUDGE = 6'h10;
  localparam logic [5:0] ADDR_JUDGE_END = 6'h1B;
  localparam logic [5:0] ADDR_STATUS = 6'h1C;
  localparam logic [5:0] ADDR_ZC_PERIOD = 6'h1D;
  // ****
  // Field positions
  // ****
  localparam int CTRL_LIQ_EN = 0;
  localparam int CTRL_CROSS_EN = 1;
  localparam int CTRL_ZC_EN = 2;
  localparam int CTRL_ACC_CTRL = 3;
  localparam int TERM_SI = 0;
  localparam int TERM_ACC = 1;
  localparam int TERM_SCALE = 2;
  localparam int TERM_LIQ = 3;
  localparam int MASK_OR_LSB = 4;
  // ****
  // Reset values and limits
  // ****
  localparam logic [3:0] RST_CTRL = 4'hF;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [15:0] RST_SINGLE = 16'h0032;
  localparam logic [15:0] RST_CROSS_XY = 16'h0032;
  localparam logic [15:0] RST_CROSS_Z = 16'h0064;
  localparam logic [15:0] RST_ZCN_TIME = 16'h0014;
  localparam logic [15:0] RST_CONT_FAIL = 16'h0258;
  localparam logic [15:0] RST_HOLD = 16'h0014;
  localparam logic [15:0] RST_LPF_HZ = 16'h000A;
  localparam logic [15:0] RST_THR_SI = 16'h0BB8;
  localparam logic [15:0] RST_THR_ACC = 16'h0FA0;
  localparam logic [15:0] RST_THR_SCALE = 16'h004F;
  localparam logic [15:0] RST_LIQ_SI = 16'h00FA;
  localparam logic [15:0] RST_LIQ_ACC = 16'h0064;
  localparam logic [15:0] RST_LIQ_DISP = 16'h000A;
  localparam logic [15:0] RST_LIQ_ZC = 16'h0032;
  localparam logic [15:0] LIMIT_MIN = 16'h0001;
  localparam logic [15:0] LIMIT_MAX = 16'h00C8;
  localparam int SINGLE_RATIO_SHIFT = 3;
  localparam int CROSS_SMALL_SHIFT = 3;
  // ****
  // Types
  // ****
  typedef struct packed {
    logic [2:0][15:0] axis;
  } sjng_accel_s;
  typedef struct packed {
    logic [15:0] si;
    logic [15:0] accControl;
    logic [15:0] accCalc;
    logic [15:0] scale;
    logic [15:0] disp;
  } sjng_pv_s;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_HOLD = 2'b01,
    PH_BLANK = 2'b10
  } sjng_phase_e;
endpackage

// ==== hdl/sjng_judgment_core.sv ====
// Purpose: Vibration and liquefaction judgment with noise guard
// Assumes: Samples and process values arrive synchronous to sys_clk
// Notes: Process values are unsigned, acceleration samples are signed Gal
// Behaviour
// - Three judgments combine four terms by AND/OR masks
// - Satisfied judgment switches its relay on
// - Reset selects no AND or OR term
// - Default thresholds 300 kine, 4000 Gal, scale 7.9
// - Three judgments reset identically
// - Acceleration term uses low-pass control value, corner 10 Hz
// - Satisfied liquefaction asserts its output
// - Liquefaction enable, on by default
// - Liquefaction uses SI, acceleration, displacement, zero-cross period
// - Enabled detector firing enters protection, noise output on
// - Protection lingers a minute after noise, outputs held, then forced off
// - Long protection declares serious failure
// - Protection flashes minor output, indicator shows it
// - Protection zeroes SI, acceleration, scale, clears judgments
// - Protection entry holds outputs at least 20 s unless serious failure forces them off
// - Single-axis detector flags one-polarity swings over its limit
// - Single-axis limit 1 to 200 Gal, default 50
// - Switchable cross-axis detector flags one large, one small axis
// - Cross-axis limits 1 to 200 Gal, Z 100, X and Y 50
// - Sign changes are crossings; their interval is the period
// - Zero-cross detector flags interval reaching time, default 20 s
`timescale 1ns/1ps
module sjng_judgment_core #(
  parameter int SEC_CYCLES = sjng_pkg::SEC_CYCLES_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [5:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  // Measurement chain
  input wire logic sampleValid,
  input wire sjng_pkg::sjng_accel_s sampleAccel,
  input wire sjng_pkg::sjng_pv_s rawPv,
  // Discrete outputs and indication
  output logic [2:0] vibrationRelay,
  output logic liquefactionOutput,
  output logic noiseGuardOutput,
  output logic seriousFaultOutput,
  output logic minorFaultOutput,
  output logic noiseIndicator,
  // Blanked values and filter setting toward the chain
  output sjng_pkg::sjng_pv_s blankedPv,
  output logic [15:0] lpfCornerHz
);
  import sjng_pkg::*;

  // ****
  // Helpers
  // ****
  // Magnitude of a signed sample
  function automatic logic [15:0] absVal(input logic [15:0] v);
    absVal = v[15] ? 16'(~v + 16'h0001) : v;
  endfunction

  // Saturating increment, never wraps
  function automatic logic [15:0] satInc(input logic [15:0] v);
    satInc = (v == 16'hFFFF) ? v : 16'(v + 16'h0001);
  endfunction

  // Low limits are kept inside their legal span
  function automatic logic [15:0] clampLimit(input logic [15:0] v);
    clampLimit = (v < LIMIT_MIN) ? LIMIT_MIN : ((v > LIMIT_MAX) ? LIMIT_MAX : v);
  endfunction

  // ****
  // Settings
  // ****
  logic [3:0] ctrl;
  logic [15:0] singleLimit;
  logic [2:0][15:0] crossLimit;
  logic [15:0] zcnTime;
  logic [15:0] contFail;
  logic [15:0] holdSec;
  logic [3:0][15:0] liqThr;
  logic [2:0][7:0] judgeMask;
  logic [2:0][2:0][15:0] judgeThr;

  // Address decode
  wire isJudge = (regAddr >= ADDR_JUDGE) && (regAddr <= ADDR_JUDGE_END);
  wire [1:0] judgeIdx = regAddr[3:2];
  wire [1:0] judgeField = regAddr[1:0];
  wire isCross = (regAddr >= ADDR_CROSS_X) && (regAddr <= ADDR_CROSS_Z);
  wire [1:0] crossIdx = 2'(regAddr - ADDR_CROSS_X);
  wire isLiq = (regAddr >= ADDR_LIQ_SI) && (regAddr <= ADDR_LIQ_ZC);
  wire [1:0] liqIdx = 2'(regAddr - ADDR_LIQ_SI);

  // Settings writes; reset gives defaults
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= RST_CTRL;
      singleLimit <= RST_SINGLE;
      crossLimit <= {RST_CROSS_Z, RST_CROSS_XY, RST_CROSS_XY};
      zcnTime <= RST_ZCN_TIME;
      contFail <= RST_CONT_FAIL;
      holdSec <= RST_HOLD;
      lpfCornerHz <= RST_LPF_HZ;
      liqThr <= {RST_LIQ_ZC, RST_LIQ_DISP, RST_LIQ_ACC, RST_LIQ_SI};
      judgeMask <= {3{RST_MASK}};
      judgeThr <= {3{RST_THR_SCALE, RST_THR_ACC, RST_THR_SI}};
    end else if (regWrite) begin
      if (regAddr == ADDR_CTRL) begin
        ctrl <= regWrData[3:0];
      end else if (regAddr == ADDR_SINGLE) begin
        singleLimit <= clampLimit(regWrData);
      end else if (isCross) begin
        crossLimit[crossIdx] <= clampLimit(regWrData);
      end else if (regAddr == ADDR_ZCN_TIME) begin
        zcnTime <= regWrData;
      end else if (regAddr == ADDR_CONT_FAIL) begin
        contFail <= regWrData;
      end else if (regAddr == ADDR_HOLD) begin
        holdSec <= regWrData;
      end else if (regAddr == ADDR_LPF) begin
        lpfCornerHz <= regWrData;
      end else if (isLiq) begin
        liqThr[liqIdx] <= regWrData;
      end else if (isJudge && judgeField == 2'h0) begin
        judgeMask[judgeIdx] <= regWrData[7:0];
      end else if (isJudge) begin
        judgeThr[judgeIdx][2'(judgeField - 2'h1)] <= regWrData;
      end
    end
  end

  // ****
  // One-second time base
  // ****
  logic [31:0] secCount;
  wire secTick = (secCount == 32'(SEC_CYCLES - 1));

  // Free-running prescaler for all second-based timers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      secCount <= 32'h00000000;
    end else begin
      secCount <= secTick ? 32'h00000000 : 32'(secCount + 32'h00000001);
    end
  end

  // ****
  // Per-axis noise detectors
  // ****
  logic [2:0][15:0] mag;
  logic [2:0] signPos;
  logic [2:0] seenSign;
  logic [2:0][15:0] zcSamples;
  logic [2:0][15:0] zcPeriod;
  logic [2:0][15:0] zcSec;
  logic [2:0][15:0] posCnt;
  logic [2:0][15:0] negCnt;
  logic [2:0] singleFlag;
  logic [2:0] crossFlag;
  logic [2:0] zcFlag;
  logic [2:0] crossing;
  logic [2:0] overSingle;
  logic [2:0] bigAxis;
  logic [2:0] smallAxis;
  logic [2:0] crossHit;
  logic [2:0] singleHit;

  // Per-axis magnitude, sign change, limits
  always_comb begin
    for (int a = 0; a < 3; a++) begin
      mag[a] = absVal(sampleAccel.axis[a]);
      crossing[a] = sampleValid && (sampleAccel.axis[a] != 16'h0000) && seenSign[a]
                    && (signPos[a] == sampleAccel.axis[a][15]);
      overSingle[a] = mag[a] >= singleLimit;
      bigAxis[a] = mag[a] >= crossLimit[a];
      smallAxis[a] = mag[a] < (crossLimit[a] >> CROSS_SMALL_SHIFT);
      zcFlag[a] = zcSec[a] >= zcnTime;
    end
    for (int a = 0; a < 3; a++) begin
      crossHit[a] = bigAxis[a] && (smallAxis[(a + 1) % 3] || smallAxis[(a + 2) % 3]);
      singleHit[a] = (19'(posCnt[a]) > (19'(negCnt[a]) << SINGLE_RATIO_SHIFT))
                     || (19'(negCnt[a]) > (19'(posCnt[a]) << SINGLE_RATIO_SHIFT));
    end
  end

  // Any enabled detector on any axis raises protection
  wire detAny = (|singleFlag) || (ctrl[CTRL_CROSS_EN] && (|crossFlag))
                || (ctrl[CTRL_ZC_EN] && (|zcFlag));

  // Detector state; polarity counts judged per second
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      signPos <= 3'h0;
      seenSign <= 3'h0;
      zcSamples <= '0;
      zcPeriod <= '0;
      zcSec <= '0;
      posCnt <= '0;
      negCnt <= '0;
      singleFlag <= 3'h0;
      crossFlag <= 3'h0;
    end else begin
      for (int a = 0; a < 3; a++) begin
        if (sampleValid && sampleAccel.axis[a] != 16'h0000) begin
          signPos[a] <= ~sampleAccel.axis[a][15];
          seenSign[a] <= 1'b1;
        end
        if (crossing[a]) begin
          zcPeriod[a] <= satInc(zcSamples[a]);
          zcSamples[a] <= 16'h0000;
        end else if (sampleValid) begin
          zcSamples[a] <= satInc(zcSamples[a]);
        end
        if (crossing[a]) begin
          zcSec[a] <= 16'h0000;
        end else if (secTick) begin
          zcSec[a] <= satInc(zcSec[a]);
        end
        if (secTick) begin
          singleFlag[a] <= singleHit[a];
          posCnt[a] <= 16'h0000;
          negCnt[a] <= 16'h0000;
        end else if (sampleValid && overSingle[a] && !sampleAccel.axis[a][15]) begin
          posCnt[a] <= satInc(posCnt[a]);
        end else if (sampleValid && overSingle[a]) begin
          negCnt[a] <= satInc(negCnt[a]);
        end
        if (sampleValid) begin
          crossFlag[a] <= crossHit[a];
        end
      end
    end
  end

  // ****
  // Protection state
  // ****
  logic protect;
  logic [15:0] lingerLeft;
  logic [15:0] protSec;
  logic [15:0] holdLeft;
  logic serious;
  logic flash;
  sjng_phase_e phase;
  wire [15:0] holdEff = (holdSec < HOLD_MIN_S) ? HOLD_MIN_S : holdSec;

  // Entry on detection, linger countdown after the last detection
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      protect <= 1'b0;
      lingerLeft <= 16'h0000;
    end else if (detAny) begin
      protect <= 1'b1;
      lingerLeft <= LINGER_TIME_S;
    end else if (protect && secTick) begin
      protect <= (lingerLeft > 16'h0001);
      lingerLeft <= (lingerLeft == 16'h0000) ? 16'h0000 : 16'(lingerLeft - 16'h0001);
    end
  end

  // Continuous protection time escalates to serious failure
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      protSec <= 16'h0000;
      serious <= 1'b0;
      flash <= 1'b0;
    end else begin
      protSec <= !protect ? 16'h0000 : (secTick ? satInc(protSec) : protSec);
      serious <= protect && (protSec >= contFail);
      flash <= protect && (secTick ? ~flash : flash);
    end
  end

  // Output hold phase: freeze, then force off until protection ends
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= PH_IDLE;
      holdLeft <= 16'h0000;
    end else begin
      case (phase)
        PH_IDLE: begin
          if (protect) begin
            phase <= PH_HOLD;
            holdLeft <= holdEff;
          end
        end
        PH_HOLD: begin
          if (!protect) begin
            phase <= PH_IDLE;
          end else if (secTick && holdLeft <= 16'h0001) begin
            phase <= PH_BLANK;
          end else if (secTick) begin
            holdLeft <= 16'(holdLeft - 16'h0001);
          end
        end
        PH_BLANK: begin
          if (!protect) begin
            phase <= PH_IDLE;
          end
        end
        default: begin
          phase <= PH_IDLE;
        end
      endcase
    end
  end

  // ****
  // Judgments
  // ****
  // Blanked process values while protected
  wire [15:0] pvSi = protect ? 16'h0000 : rawPv.si;
  wire [15:0] pvAccCtl = protect ? 16'h0000 : rawPv.accControl;
  wire [15:0] pvAccCalc = protect ? 16'h0000 : rawPv.accCalc;
  wire [15:0] pvScale = protect ? 16'h0000 : rawPv.scale;
  wire [15:0] pvAcc = ctrl[CTRL_ACC_CTRL] ? pvAccCtl : pvAccCalc;

  // Longest recent crossing interval over the three axes
  wire [15:0] zcMaxXY = (zcPeriod[0] > zcPeriod[1]) ? zcPeriod[0] : zcPeriod[1];
  wire [15:0] zcMax = (zcMaxXY > zcPeriod[2]) ? zcMaxXY : zcPeriod[2];

  // Liquefaction needs all four indicators at once
  wire liqCond = (pvSi >= liqThr[0]) && (pvAccCalc >= liqThr[1])
                 && (rawPv.disp >= liqThr[2]) && (zcMax >= liqThr[3]);
  wire liqResult = ctrl[CTRL_LIQ_EN] && !protect && liqCond;

  logic [2:0][3:0] terms;
  logic [2:0] vibResult;

  // AND group needs all its terms, OR group any; empty groups never fire
  always_comb begin
    for (int j = 0; j < 3; j++) begin
      terms[j][TERM_SI] = pvSi >= judgeThr[j][0];
      terms[j][TERM_ACC] = pvAcc >= judgeThr[j][1];
      terms[j][TERM_SCALE] = pvScale >= judgeThr[j][2];
      terms[j][TERM_LIQ] = liqResult;
      vibResult[j] = !protect && (((judgeMask[j][3:0] != 4'h0)
                     && ((terms[j] & judgeMask[j][3:0]) == judgeMask[j][3:0]))
                     || ((terms[j] & judgeMask[j][MASK_OR_LSB +: 4]) != 4'h0));
    end
  end

  // ****
  // Outputs
  // ****
  // Serious or blank forces off; hold keeps the last value
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      vibrationRelay <= 3'h0;
      liquefactionOutput <= 1'b0;
    end else if (serious || phase == PH_BLANK) begin
      vibrationRelay <= 3'h0;
      liquefactionOutput <= 1'b0;
    end else if (!protect) begin
      vibrationRelay <= vibResult;
      liquefactionOutput <= liqResult;
    end
  end

  // Fault and indicator outputs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      noiseGuardOutput <= 1'b0;
      seriousFaultOutput <= 1'b0;
      minorFaultOutput <= 1'b0;
      noiseIndicator <= 1'b0;
      blankedPv <= '0;
    end else begin
      noiseGuardOutput <= protect;
      seriousFaultOutput <= serious;
      minorFaultOutput <= protect && flash;
      noiseIndicator <= protect;
      blankedPv <= '{si: pvSi, accControl: pvAccCtl, accCalc: pvAccCalc,
                     scale: pvScale, disp: rawPv.disp};
    end
  end

  // ****
  // Register read
  // ****
  logic [15:0] readValue;
  wire [15:0] statusWord = {2'h0, liquefactionOutput, phase, serious, protect,
                            zcFlag, crossFlag, singleFlag};

  // Unmapped addresses read as zero
  always_comb begin
    if (regAddr == ADDR_CTRL) begin
      readValue = {12'h000, ctrl};
    end else if (regAddr == ADDR_SINGLE) begin
      readValue = singleLimit;
    end else if (isCross) begin
      readValue = crossLimit[crossIdx];
    end else if (regAddr == ADDR_ZCN_TIME) begin
      readValue = zcnTime;
    end else if (regAddr == ADDR_CONT_FAIL) begin
      readValue = contFail;
    end else if (regAddr == ADDR_HOLD) begin
      readValue = holdSec;
    end else if (regAddr == ADDR_LPF) begin
      readValue = lpfCornerHz;
    end else if (isLiq) begin
      readValue = liqThr[liqIdx];
    end else if (isJudge && judgeField == 2'h0) begin
      readValue = {8'h00, judgeMask[judgeIdx]};
    end else if (isJudge) begin
      readValue = judgeThr[judgeIdx][2'(judgeField - 2'h1)];
    end else if (regAddr == ADDR_STATUS) begin
      readValue = statusWord;
    end else if (regAddr == ADDR_ZC_PERIOD) begin
      readValue = zcMax;
    end else begin
      readValue = 16'h0000;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 16'h0000;
    end else begin
      regRdData <= regRead ? readValue : 16'h0000;
    end
  end
endmodule

// ==== tb/sjng_checker.sv ====
// Purpose: Port checker for the judgment core
// Assumes: SEC_CYCLES is the shortened second of the bench
// Notes: Bound to every core instance at the foot
`timescale 1ns/1ps
module sjng_checker #(
  parameter int SEC_CYCLES = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [5:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regRdData,
  // Outputs
  input wire logic [2:0] vibrationRelay,
  input wire logic liquefactionOutput,
  input wire logic noiseGuardOutput,
  input wire logic seriousFaultOutput,
  input wire logic minorFaultOutput,
  input wire logic noiseIndicator,
  input wire sjng_pkg::sjng_pv_s blankedPv,
  input wire logic [15:0] lpfCornerHz
);
  import sjng_pkg::*;
  // Flash toggles per tick; slack for a partial first tick
  localparam int FLASH_WIN = 2 * SEC_CYCLES + 2;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Guard on two edges skips entry and exit cycles
  sequence sGuardSteady;
    $past(noiseGuardOutput) && noiseGuardOutput;
  endsequence
  sequence sToggle;
    ##[1:FLASH_WIN] $changed(minorFaultOutput);
  endsequence
  AST_IND: assert property (noiseIndicator == noiseGuardOutput)
    else $error("indicator differs from guard output");
  AST_BLANK: assert property (sGuardSteady |-> {blankedPv.si, blankedPv.accControl,
    blankedPv.accCalc, blankedPv.scale} == 64'h0) else $error("values not blanked");
  AST_NO_RISE: assert property (sGuardSteady |->
    (vibrationRelay & ~$past(vibrationRelay)) == 3'h0 && !$rose(liquefactionOutput))
    else $error("output rose while guarded");
  AST_FLASH: assert property ($rose(noiseGuardOutput) |-> sToggle)
    else $error("minor output not flashing");
  AST_MINOR: assert property (!noiseGuardOutput && !$past(noiseGuardOutput)
    |-> !minorFaultOutput) else $error("minor output outside guard");
  AST_SER_RISE: assert property ($rose(seriousFaultOutput) |-> noiseGuardOutput)
    else $error("serious without guard");
  AST_SER_OFF: assert property (seriousFaultOutput && $past(seriousFaultOutput)
    |-> vibrationRelay == 3'h0 && !liquefactionOutput) else $error("outputs on in serious");
  AST_LPF: assert property (regWrite && regAddr == ADDR_LPF
    |=> lpfCornerHz == $past(regWrData)) else $error("corner not updated");
  AST_RD0: assert property (!$past(regRead) |-> regRdData == 16'h0000)
    else $error("read data outside its cycle");
endmodule
bind sjng_judgment_core sjng_checker #(.SEC_CYCLES(SEC_CYCLES)) u_chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .vibrationRelay(vibrationRelay), .liquefactionOutput(liquefactionOutput),
  .noiseGuardOutput(noiseGuardOutput), .seriousFaultOutput(seriousFaultOutput),
  .minorFaultOutput(minorFaultOutput), .noiseIndicator(noiseIndicator),
  .blankedPv(blankedPv), .lpfCornerHz(lpfCornerHz));

// ==== tb/sjng_front_end.sv ====
// Purpose: Behavioural accelerometer front end
// Assumes: Amplitudes and process values set by the bench
// Notes: Sign alternates each sample; bias pins X positive
`timescale 1ns/1ps
module sjng_front_end (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Scenario controls
  input wire logic [2:0][15:0] amp,
  input wire logic bias,
  input wire logic slow,
  input wire sjng_pkg::sjng_pv_s pvIn,
  // Toward the core
  output logic sampleValid,
  output sjng_pkg::sjng_accel_s sampleAccel,
  output sjng_pkg::sjng_pv_s rawPv
);
  import sjng_pkg::*;
  logic neg;
  logic phase;
  // Slow mode skips every other cycle; stale samples are scrambled
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {neg, phase, sampleValid, sampleAccel, rawPv} <= '0;
    end else begin
      phase <= ~phase;
      sampleValid <= !slow || phase;
      rawPv <= pvIn;
      sampleAccel <= ~sampleAccel;
      if (!slow || phase) begin
        neg <= ~neg;
        for (int i = 0; i < 3; i++) begin
          sampleAccel.axis[i] <= (neg && !(bias && i == 0)) ? -amp[i] : amp[i];
        end
      end
    end
  end
endmodule

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench of the judgment core
// Assumes: One second is shortened to SEC cycles
// Notes: Random values come from a fixed xorshift seed
`timescale 1ns/1ps
module testbench;
  import sjng_pkg::*;
  localparam int SEC = 20;
  logic sys_clk, rst_b, regWrite, regRead, bias, slow, sampleValid, liquefactionOutput;
  logic noiseGuardOutput, seriousFaultOutput, minorFaultOutput, noiseIndicator;
  logic [5:0] regAddr;
  logic [15:0] regWrData, regRdData, lpfCornerHz, d, got;
  logic [2:0] vibrationRelay;
  logic [2:0][15:0] amp;
  logic [31:0] seed;
  int miscompares, check_count, flips;
  sjng_accel_s sampleAccel;
  sjng_pv_s pv, rawPv, blankedPv;
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  sjng_front_end fe (.sys_clk(sys_clk), .rst_b(rst_b), .amp(amp), .bias(bias), .slow(slow),
    .pvIn(pv), .sampleValid(sampleValid), .sampleAccel(sampleAccel), .rawPv(rawPv));
  sjng_judgment_core #(.SEC_CYCLES(SEC)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .sampleValid(sampleValid), .sampleAccel(sampleAccel),
    .rawPv(rawPv), .vibrationRelay(vibrationRelay), .liquefactionOutput(liquefactionOutput),
    .noiseGuardOutput(noiseGuardOutput), .seriousFaultOutput(seriousFaultOutput),
    .minorFaultOutput(minorFaultOutput), .noiseIndicator(noiseIndicator),
    .blankedPv(blankedPv), .lpfCornerHz(lpfCornerHz));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Limit settings saturate rather than reject
  function automatic logic [15:0] lim(input logic [15:0] v);
    return (v < 16'h0001) ? 16'h0001 : (v > 16'h00C8) ? 16'h00C8 : v;
  endfunction
  function automatic logic [15:0] relays(input logic [15:0] si, acc, input logic liq);
    return {13'h0, acc >= 16'h0FA0, liq, si >= 16'h0BB8};
  endfunction
  task automatic chk(input logic [15:0] g, e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(negedge sys_clk);
    chk(regRdData, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic end_sim;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog well above the roughly 3600 cycles of the tests
  initial begin
    repeat (12000) @(posedge sys_clk);
    miscompares++;
    end_sim;
  end
  initial begin
    {rst_b, regWrite, regRead, regAddr, regWrData, bias, slow, pv} = '0;
    amp = {3{16'h0008}};
    seed = 32'h5E31;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    wt(1);
    chk(lpfCornerHz, 16'h000A);
    rchk(ADDR_CTRL, 16'h000F);
    rchk(ADDR_SINGLE, 16'h0032);
    rchk(ADDR_CROSS_X, 16'h0032);
    rchk(ADDR_CROSS_Z, 16'h0064);
    rchk(ADDR_ZCN_TIME, 16'h0014);
    rchk(6'h3F, 16'h0000);
    for (int j = 0; j < 12; j++) begin
      rchk(ADDR_JUDGE + 6'(j), j[1:0] == 0 ? 16'h0000 : j[1:0] == 1 ? 16'h0BB8
        : j[1:0] == 2 ? 16'h0FA0 : 16'h004F);
    end
    wr(ADDR_LPF, 16'h0005);
    rchk(ADDR_LPF, 16'h0005);
    // Out-of-range limits saturate; corners first, then random
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      d = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : {8'h00, seed[7:0]};
      wr(ADDR_SINGLE, d);
      rchk(ADDR_SINGLE, lim(d));
      wr(ADDR_CROSS_Z, d);
      rchk(ADDR_CROSS_Z, lim(d));
    end
    wr(ADDR_SINGLE, 16'h0032);
    wr(ADDR_CROSS_Z, 16'h0064);
    $display("test settings done");
    // Relay 0 on SI, relay 1 on liquefaction, relay 2 on control acceleration
    wr(ADDR_JUDGE, 16'h0001);
    wr(ADDR_JUDGE + 6'h04, 16'h0008);
    wr(ADDR_JUDGE + 6'h08, 16'h0020);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      d = seed[0] ? 16'h0BB8 + seed[11:4] : {5'h00, seed[14:4]};
      got = seed[1] ? 16'h0FA0 + seed[23:16] : {5'h00, seed[26:16]};
      @(posedge sys_clk);
      slow <= seed[2];
      pv <= '{d, got, ~got, 16'h0000, 16'h0000};
      wt(3);
      chk({13'h0, vibrationRelay}, relays(d, got, 1'b0));
    end
    // Liquefaction needs its enable and the displacement term
    wr(ADDR_LIQ_ZC, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, (i != 0) ? 16'h000F : 16'h000E);
      @(posedge sys_clk);
      pv <= '{16'h012C, 16'h0000, 16'h00C8, 16'h0000, (i == 2) ? 16'h0000 : 16'h0014};
      wt(3);
      chk({15'h0, liquefactionOutput}, {15'h0, i != 0 && i != 2});
      chk({13'h0, vibrationRelay}, relays(16'h0, 16'h0, i != 0 && i != 2));
    end
    $display("test judgment done");
    @(posedge sys_clk);
    pv <= '{16'h0C00, 16'h0000, 16'h0000, 16'h0000, 16'h0014};
    amp[0] <= 16'h003C;
    wt(5);
    chk({15'h0, noiseGuardOutput}, 16'h0001);
    chk(blankedPv.si, 16'h0000);
    chk(blankedPv.disp, 16'h0014);
    flips = 0;
    for (int i = 0; i < 3 * SEC; i++) begin
      got[0] = minorFaultOutput;
      @(negedge sys_clk);
      flips += int'(got[0] !== minorFaultOutput);
    end
    chk({15'h0, flips >= 2}, 16'h0001);
    wt(7 * SEC);
    chk({13'h0, vibrationRelay}, 16'h0001);
    wt(15 * SEC);
    chk({13'h0, vibrationRelay}, 16'h0000);
    @(posedge sys_clk);
    amp[0] <= 16'h0001;
    wt(55 * SEC);
    chk({15'h0, noiseGuardOutput}, 16'h0001);
    wt(11 * SEC);
    chk({15'h0, noiseGuardOutput}, 16'h0000);
    wt(2);
    chk({13'h0, vibrationRelay}, 16'h0001);
    $display("test cross-axis done");
    // Cross detector off, then a one-sided swing trips the single-axis detector
    wr(ADDR_CTRL, 16'h000D);
    wr(ADDR_CONT_FAIL, 16'h0003);
    @(posedge sys_clk);
    amp[0] <= 16'h003C;
    wt(3 * SEC);
    chk({15'h0, noiseGuardOutput}, 16'h0000);
    @(posedge sys_clk);
    bias <= 1'b1;
    wt(3 * SEC);
    chk({15'h0, noiseGuardOutput}, 16'h0001);
    wt(4 * SEC);
    chk({14'h0, seriousFaultOutput, vibrationRelay[0]}, 16'h0002);
    @(posedge sys_clk);
    {bias, amp[0]} <= {1'b0, 16'h0001};
    wt(66 * SEC);
    chk({14'h0, seriousFaultOutput, noiseGuardOutput}, 16'h0000);
    $display("test single-axis done");
    // No crossings at all once every axis reads zero
    wr(ADDR_ZCN_TIME, 16'h0002);
    @(posedge sys_clk);
    amp <= '0;
    wt(SEC / 2);
    chk({15'h0, noiseGuardOutput}, 16'h0000);
    wt(4 * SEC);
    chk({15'h0, noiseGuardOutput}, 16'h0001);
    $display("test zero-cross done");
    end_sim;
  end
endmodule
